// File: rtl/scc_pkg.sv
// How it works
// - DMA sends exactly the programmed 12-bit length unless continuous transmit is set
// - transfer mode bit: interrupt or DMA
// - carrier auto start, else general input outside clock modes 1 and 5
// - continuous transmit ignores byte count
// - power bit: standby or active
// - master clock, never in clock mode 5
// - port coding select, bus uses NRZ
// - protocol select field
// - idle fill: ones or sync characters
// - eight clock modes, mode 5 needs variant
// - bus config request-to-send control
// - point-to-point data pin swap
// - mode 5 clock shift 0 to 7
// - baud divider off divides by one
// - baud factor is (N+1) times 2, except N of 1023, which divides by one
// - transmit clock pin output enable
// - strobe exchange while acknowledge active
// - NRZ data inversion both directions
// - preamble repeated 1, 2, 4, 8 times
// - preamble between idle fill and data
// - CRC include tag stored per character
// - CRC init level per frame
// - CRC accumulated and appended after message end
package scc_pkg;
   localparam logic [7:0] OFF_TX_CNT_LO = 8'h2a;
   localparam logic [7:0] OFF_CNT_HI = 8'h2b;
   localparam logic [7:0] OFF_CFG_A = 8'h2c;
   localparam logic [7:0] OFF_CFG_B = 8'h2d;
   localparam logic [7:0] OFF_CFG_C = 8'h2e;
   localparam logic [7:0] OFF_CFG_D = 8'h2f;
   localparam logic [7:0] RST_REG = 8'h00;
   // high count register fields
   localparam int HI_DMA = 7;
   localparam int HI_CAS = 5;
   localparam int HI_XC = 4;
   // config a
   localparam int A_PWR = 7;
   localparam int A_MCE = 6;
   localparam int A_SC = 2;
   localparam int A_SM = 0;
   // config b
   localparam int B_ITF = 3;
   localparam int B_CM = 0;
   localparam logic [7:0] B_MASK = 8'h1f;
   // config c
   localparam int C_SOC = 6;
   localparam int C_BR = 6;
   localparam int C_BDF = 5;
   localparam int C_XCS = 5;
   localparam int C_RCS = 4;
   localparam int C_TOE = 3;
   localparam int C_RWX = 2;
   localparam int C_DIV = 0;
   // config d
   localparam int D_PRE = 6;
   localparam int D_EPT = 5;
   localparam int D_CON = 4;
   localparam int D_CRL = 3;
   localparam int D_CRC_APPEND = 2;
   localparam int D_CRCM = 1;
   localparam logic [15:0] CRC_INIT_ONES = 16'hffff;
   localparam logic [15:0] CRC_INIT_ZERO = 16'h0000;
   localparam logic [15:0] POLY_CRC16 = 16'h8005;
   localparam logic [15:0] POLY_CCITT = 16'h1021;
   localparam logic [2:0] CM_ONE = 3'h1;
   localparam logic [2:0] CM_FIVE = 3'h5;
   typedef enum logic [2:0] {
      COD_NRZ = 3'h0, COD_BUS1 = 3'h1, COD_NRZI = 3'h2, COD_BUS2 = 3'h3,
      COD_FM0 = 3'h4, COD_FM1 = 3'h5, COD_MAN = 3'h6, COD_NONE = 3'h7
   } scc_coding_t;
   typedef enum logic [1:0] {
      PR_HDLC = 2'h0, PR_LOOP = 2'h1, PR_BISYNC = 2'h2, PR_ASYNC = 2'h3
   } scc_proto_t;
   typedef enum logic [2:0] {
      TS_IDLE = 3'h0, TS_PRE = 3'h1, TS_DATA = 3'h2, TS_CRC1 = 3'h3, TS_CRC2 = 3'h4
   } scc_txst_t;
   typedef enum logic [2:0] {
      SRC_ONES = 3'h0, SRC_SYNC = 3'h1, SRC_PRE = 3'h2, SRC_DATA = 3'h3, SRC_CRC = 3'h4
   } scc_src_t;
endpackage

// File: rtl/scc_chan_cfg.sv
module scc_chan_cfg #(
   parameter bit HAS_TSA = 1'b1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // commands and transmit path
   input wire logic transmit_frame_cmd,
   input wire logic message_end_cmd,
   input wire logic byte_tick,
   input wire logic tx_byte_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_byte_tag,
   input wire logic transmit_queue_wr,
   output logic [1:0] transmit_queue_tag,
   output scc_pkg::scc_src_t tx_source,
   output logic [15:0] crc_value,
   // dma
   input wire logic transfer_acknowledge,
   input wire logic other_chan_exchange,
   output logic dma_request,
   output logic strobe_exchange_active,
   // line side
   input wire logic carrier_detect_in,
   input wire logic frame_receiving,
   input wire logic transmitting,
   output logic rx_enable,
   output logic carrier_general,
   output logic rts_b,
   output logic swap_data_pins,
   output logic invert_data,
   // clocking
   input wire logic [7:0] baud_value_low,
   input wire logic [1:0] tx_shift_upper,
   input wire logic [1:0] rx_shift_upper,
   output logic [2:0] tx_clock_shift,
   output logic [2:0] rx_clock_shift,
   output logic baud_tick,
   input wire logic tx_clock_pin_in,
   output logic tx_clock_pin_out,
   output logic tx_clock_pin_oe,
   // static configuration
   output logic power_active,
   output logic master_clock_enable,
   output scc_pkg::scc_coding_t port_coding_select,
   output scc_pkg::scc_proto_t protocol_select,
   output logic [2:0] clock_mode_select,
   output logic continuous_transmit
);
   typedef struct packed {
      logic [7:0] cnt_lo;
      logic dma;
      logic cas;
      logic xc;
      logic [3:0] cnt_hi;
      logic [7:0] cfg_a;
      logic [7:0] cfg_b;
      logic [7:0] cfg_c;
      logic [7:0] cfg_d;
      logic [7:0] rdata;
      logic [11:0] left;
      logic run_cont;
      logic [2:0] cd_s;
      logic cd_f;
      logic [2:0] ack_s;
      logic ack_f;
      scc_pkg::scc_txst_t st;
      logic [2:0] rep;
      logic me;
      logic [15:0] crc;
      logic [1:0] tag;
      logic [10:0] bcnt;
      logic btick;
      logic tx_clock_pin;
   } scc_state_t;

   scc_state_t s_reg, s_next;

   initial begin
      if (HAS_TSA !== 1'b0 && HAS_TSA !== 1'b1) begin
         $error("HAS_TSA must be 0 or 1");
      end
   end

   function automatic logic [15:0] crc_step(
      input logic [15:0] c, input logic [7:0] d, input logic [15:0] p);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         if (r[15] ^ d[i]) begin
            r = {r[14:0], 1'b0} ^ p;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction

   localparam int B_CM_HI = scc_pkg::B_CM + 2;

   // decoded configuration
   logic [2:0] cm;
   logic [2:0] sc;
   logic bus_cfg;
   logic [1:0] soc;
   logic [9:0] baud_n;
   logic [10:0] factor;
   logic [11:0] tx_len;
   logic ack_rise;
   logic [3:0] pre_times;

   always_comb begin
      cm = s_reg.cfg_b[B_CM_HI:scc_pkg::B_CM];
      sc = s_reg.cfg_a[scc_pkg::A_SC+2:scc_pkg::A_SC];
      bus_cfg = (sc == scc_pkg::COD_BUS1) || (sc == scc_pkg::COD_BUS2);
      soc = s_reg.cfg_c[scc_pkg::C_SOC+1:scc_pkg::C_SOC];
      baud_n = {s_reg.cfg_c[scc_pkg::C_BR+1:scc_pkg::C_BR], baud_value_low};
      factor = s_reg.cfg_c[scc_pkg::C_BDF] ? {baud_n + 10'h001, 1'b0} : 11'h001;
      if (baud_n == 10'h3ff && s_reg.cfg_c[scc_pkg::C_BDF]) begin
         factor = 11'h000;
      end
      tx_len = {s_reg.cnt_hi, s_reg.cnt_lo};
      // filtered acknowledge is about to go high: stages 2 and 3 agree on one
      ack_rise = (s_reg.ack_s[1] == s_reg.ack_s[2]) && s_reg.ack_s[2] && !s_reg.ack_f;
      pre_times = 4'h1 << s_reg.cfg_d[scc_pkg::D_PRE+1:scc_pkg::D_PRE];
   end

   always_comb begin
      s_next = s_reg;
      // three-stage pin synchronisers, change counts when stages 2 and 3 agree
      s_next.cd_s = {s_reg.cd_s[1:0], carrier_detect_in};
      s_next.ack_s = {s_reg.ack_s[1:0], transfer_acknowledge};
      if (s_reg.cd_s[1] == s_reg.cd_s[2]) begin
         s_next.cd_f = s_reg.cd_s[2];
      end
      if (s_reg.ack_s[1] == s_reg.ack_s[2]) begin
         s_next.ack_f = s_reg.ack_s[2];
      end
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            scc_pkg::OFF_TX_CNT_LO: s_next.cnt_lo = reg_wdata;
            scc_pkg::OFF_CNT_HI: begin
               s_next.dma = reg_wdata[scc_pkg::HI_DMA];
               s_next.cas = reg_wdata[scc_pkg::HI_CAS];
               s_next.xc = reg_wdata[scc_pkg::HI_XC];
               s_next.cnt_hi = reg_wdata[3:0];
            end
            scc_pkg::OFF_CFG_A: s_next.cfg_a = reg_wdata & 8'hdf;
            scc_pkg::OFF_CFG_B: begin
               s_next.cfg_b = reg_wdata & scc_pkg::B_MASK;
               // without the time-slot variant mode 5 cannot be selected
               if (!HAS_TSA && reg_wdata[2:0] == scc_pkg::CM_FIVE) begin
                  s_next.cfg_b[2:0] = s_reg.cfg_b[2:0];
               end
            end
            scc_pkg::OFF_CFG_C: s_next.cfg_c = reg_wdata & 8'hfd;
            scc_pkg::OFF_CFG_D: s_next.cfg_d = reg_wdata;
            default: begin
            end
         endcase
      end
      // register reads, unmapped and write-only read zero
      if (reg_rd) begin
         case (reg_addr)
            scc_pkg::OFF_CNT_HI: s_next.rdata = {s_reg.dma, 1'b0, s_reg.cas, 5'h00};
            scc_pkg::OFF_CFG_A: s_next.rdata = s_reg.cfg_a;
            scc_pkg::OFF_CFG_B: s_next.rdata = s_reg.cfg_b;
            scc_pkg::OFF_CFG_C: s_next.rdata = s_reg.cfg_c;
            scc_pkg::OFF_CFG_D: s_next.rdata = s_reg.cfg_d;
            default: s_next.rdata = 8'h00;
         endcase
      end
      // dma length, counted down on each acknowledge rising edge
      if (transmit_frame_cmd && s_reg.dma) begin
         s_next.left = tx_len;
         s_next.run_cont = s_reg.xc;
      end else if (ack_rise && s_reg.left != 12'h000) begin
         s_next.left = s_reg.left - 12'h001;
      end
      if (message_end_cmd || !s_reg.dma) begin
         s_next.run_cont = 1'b0;
      end
      // tag copied with each queue write; both characters of a word
      if (transmit_queue_wr) begin
         s_next.tag = {2{s_reg.cfg_d[scc_pkg::D_CON]}};
      end
      if (message_end_cmd) begin
         s_next.me = 1'b1;
      end
      // transmit sequencer
      case (s_reg.st)
         scc_pkg::TS_IDLE: begin
            if (transmit_frame_cmd) begin
               s_next.me = message_end_cmd;
               s_next.crc = s_reg.cfg_d[scc_pkg::D_CRL] ?
                  scc_pkg::CRC_INIT_ZERO : scc_pkg::CRC_INIT_ONES;
               s_next.rep = 3'(pre_times - 4'h1);
               s_next.st = s_reg.cfg_d[scc_pkg::D_EPT] ?
                  scc_pkg::TS_PRE : scc_pkg::TS_DATA;
            end
         end
         scc_pkg::TS_PRE: begin
            if (byte_tick) begin
               if (s_reg.rep == 3'h0) begin
                  s_next.st = scc_pkg::TS_DATA;
               end else begin
                  s_next.rep = s_reg.rep - 3'h1;
               end
            end
         end
         scc_pkg::TS_DATA: begin
            if (byte_tick && tx_byte_valid) begin
               if (tx_byte_tag && s_reg.cfg_d[scc_pkg::D_CRC_APPEND]) begin
                  s_next.crc = crc_step(s_reg.crc, tx_byte,
                     s_reg.cfg_d[scc_pkg::D_CRCM] ?
                     scc_pkg::POLY_CCITT : scc_pkg::POLY_CRC16);
               end
            end else if (byte_tick && s_reg.me) begin
               s_next.st = s_reg.cfg_d[scc_pkg::D_CRC_APPEND] ?
                  scc_pkg::TS_CRC1 : scc_pkg::TS_IDLE;
            end
         end
         scc_pkg::TS_CRC1: begin
            if (byte_tick) begin
               s_next.st = scc_pkg::TS_CRC2;
            end
         end
         scc_pkg::TS_CRC2: begin
            if (byte_tick) begin
               s_next.st = scc_pkg::TS_IDLE;
            end
         end
         default: s_next.st = scc_pkg::TS_IDLE;
      endcase
      // baud generator; a tick every factor cycles
      s_next.btick = 1'b0;
      if (s_reg.bcnt + 11'h001 >= factor) begin
         s_next.bcnt = 11'h000;
         s_next.btick = 1'b1;
         s_next.tx_clock_pin = !s_reg.tx_clock_pin;
      end else begin
         s_next.bcnt = s_reg.bcnt + 11'h001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   // outputs
   always_comb begin
      reg_rdata = s_reg.rdata;
      power_active = s_reg.cfg_a[scc_pkg::A_PWR];
      master_clock_enable = s_reg.cfg_a[scc_pkg::A_MCE] && cm != scc_pkg::CM_FIVE;
      port_coding_select = scc_pkg::scc_coding_t'(sc);
      protocol_select = scc_pkg::scc_proto_t'(s_reg.cfg_a[1:0]);
      clock_mode_select = cm;
      // the bit only means something in dma mode
      continuous_transmit = s_reg.dma && s_reg.xc;
      dma_request = s_reg.dma && (s_reg.run_cont || s_reg.left != 12'h000);
      strobe_exchange_active = s_reg.dma && s_reg.ack_f &&
         (s_reg.cfg_c[scc_pkg::C_RWX] || other_chan_exchange);
      rx_enable = s_reg.cas ? s_reg.cd_f : 1'b1;
      carrier_general = !s_reg.cas && cm != scc_pkg::CM_ONE &&
         cm != scc_pkg::CM_FIVE && s_reg.cd_f;
      if (!bus_cfg || !soc[1]) begin
         rts_b = !(bus_cfg && transmitting);
      end else if (!soc[0]) begin
         rts_b = 1'b1;
      end else begin
         rts_b = !frame_receiving;
      end
      swap_data_pins = !bus_cfg && soc[1];
      invert_data = s_reg.cfg_c[scc_pkg::C_DIV] && sc == scc_pkg::COD_NRZ;
      tx_clock_shift = 3'h0;
      rx_clock_shift = 3'h0;
      if (cm == scc_pkg::CM_FIVE) begin
         tx_clock_shift = {tx_shift_upper, s_reg.cfg_c[scc_pkg::C_XCS]};
         rx_clock_shift = {rx_shift_upper, s_reg.cfg_c[scc_pkg::C_RCS]};
      end
      baud_tick = s_reg.btick;
      tx_clock_pin_out = s_reg.tx_clock_pin;
      tx_clock_pin_oe = s_reg.cfg_c[scc_pkg::C_TOE] && cm != 3'h0 &&
         cm != scc_pkg::CM_ONE;
      transmit_queue_tag = s_reg.tag;
      crc_value = s_reg.crc;
      case (s_reg.st)
         scc_pkg::TS_IDLE: tx_source = s_reg.cfg_b[scc_pkg::B_ITF] ?
            scc_pkg::SRC_SYNC : scc_pkg::SRC_ONES;
         scc_pkg::TS_PRE: tx_source = scc_pkg::SRC_PRE;
         scc_pkg::TS_DATA: tx_source = scc_pkg::SRC_DATA;
         default: tx_source = scc_pkg::SRC_CRC;
      endcase
   end

   // the pin input is never sampled; it only drives an unused signal
   logic unused_clk_in;
   assign unused_clk_in = tx_clock_pin_in;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   dma_load_a: assert property (clk_en && transmit_frame_cmd && s_reg.dma
      |=> s_reg.left == $past(tx_len))
      else $error("dma length not loaded");
   dma_off_a: assert property (!s_reg.dma |-> !dma_request)
      else $error("dma request in interrupt mode");
   cont_a: assert property (clk_en && transmit_frame_cmd && s_reg.dma && s_reg.xc
      |=> dma_request)
      else $error("continuous transmit not requesting");
   mce5_a: assert property (cm == scc_pkg::CM_FIVE |-> !master_clock_enable)
      else $error("master clock in mode 5");
   swap_a: assert property (swap_data_pins |-> !bus_cfg && soc[1])
      else $error("pin swap outside point-to-point");
   baud1_a: assert property (!s_reg.cfg_c[scc_pkg::C_BDF] && clk_en
      && $past(clk_en) && $past(rst_b) && !$past(reg_wr) |-> baud_tick)
      else $error("undivided baud not ticking every cycle");
   factor_a: assert property (s_reg.cfg_c[scc_pkg::C_BDF] && baud_n != 10'h3ff
      |-> factor == {baud_n + 10'h001, 1'b0})
      else $error("baud factor wrong");
   crcinit_a: assert property (clk_en && s_reg.st == scc_pkg::TS_IDLE
      && transmit_frame_cmd |=> crc_value == ($past(s_reg.cfg_d[scc_pkg::D_CRL])
      ? scc_pkg::CRC_INIT_ZERO : scc_pkg::CRC_INIT_ONES))
      else $error("crc init value wrong");
   pre_a: assert property (clk_en && s_reg.st == scc_pkg::TS_IDLE && transmit_frame_cmd
      && s_reg.cfg_d[scc_pkg::D_EPT] |=> tx_source == scc_pkg::SRC_PRE)
      else $error("preamble not started");
   inv_a: assert property (invert_data |-> sc == scc_pkg::COD_NRZ)
      else $error("inversion outside NRZ");

   dma_done_c: cover property (dma_request ##[1:200] !dma_request);
   crc_out_c: cover property (tx_source == scc_pkg::SRC_CRC);
   pre_out_c: cover property (tx_source == scc_pkg::SRC_PRE ##1 tx_source == scc_pkg::SRC_DATA);
   exch_c: cover property (strobe_exchange_active);
endmodule // scc_chan_cfg

// File: tb/scc_dma_host.sv
module scc_dma_host (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // dma handshake
   input wire logic dma_request,
   input wire logic slow,
   output logic transfer_acknowledge,
   output int ack_count
);
   timeunit 1ns;
   timeprecision 1ns;
   int phase;
   // one acknowledge per standing request, then a back-off long enough for the
   // device to resynchronise and drop its request after the last cycle
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 0;
         transfer_acknowledge <= 1'b0;
         ack_count <= 0;
      end else if (phase == 0) begin
         if (dma_request) begin
            transfer_acknowledge <= 1'b1;
            ack_count <= ack_count + 1;
            phase <= 1;
         end
      end else begin
         phase <= (phase == (slow ? 14 : 8)) ? 0 : phase + 1;
         if (phase == 2) begin
            transfer_acknowledge <= 1'b0;
         end
      end
   end
endmodule // scc_dma_host

// File: tb/scc_chan_cfg_tb.sv
module scc_chan_cfg_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_byte = 8'h00, baud_value_low = 8'h00;
   logic transmit_frame_cmd = 1'b0, message_end_cmd = 1'b0, byte_tick = 1'b0;
   logic tx_byte_valid = 1'b0, tx_byte_tag = 1'b0, transmit_queue_wr = 1'b0;
   logic other_chan_exchange = 1'b0, carrier_detect_in = 1'b0, frame_receiving = 1'b0;
   logic transmitting = 1'b0, slow = 1'b0, seen_xchg = 1'b0;
   logic [1:0] tx_shift_upper = 2'h0, rx_shift_upper = 2'h0, transmit_queue_tag;
   logic [7:0] reg_rdata;
   logic [15:0] crc_value;
   logic [2:0] clock_mode_select, tx_clock_shift, rx_clock_shift;
   scc_pkg::scc_src_t tx_source;
   scc_pkg::scc_coding_t port_coding_select;
   scc_pkg::scc_proto_t protocol_select;
   logic dma_request, strobe_exchange_active, rx_enable, carrier_general, rts_b;
   logic swap_data_pins, invert_data, baud_tick, tx_clock_pin_out, tx_clock_pin_oe;
   logic power_active, master_clock_enable, continuous_transmit, transfer_acknowledge;
   int ack_count, n0, n, g;
   int bad_count = 0;
   int checks_done = 0;
   localparam logic [23:0] ROWS [7] = '{24'h2cffdf, 24'h2dff1f, 24'h2efffd, 24'h2fffff,
      24'h2bf5a0, 24'h2aff00, 24'h30ff00};

   scc_chan_cfg i_dut (.core_clk, .rst_b, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .transmit_frame_cmd, .message_end_cmd, .byte_tick, .tx_byte_valid, .tx_byte,
      .tx_byte_tag, .transmit_queue_wr, .transmit_queue_tag, .tx_source, .crc_value,
      .transfer_acknowledge, .other_chan_exchange, .dma_request, .strobe_exchange_active,
      .carrier_detect_in, .frame_receiving, .transmitting, .rx_enable, .carrier_general,
      .rts_b, .swap_data_pins, .invert_data, .baud_value_low, .tx_shift_upper,
      .rx_shift_upper, .tx_clock_shift, .rx_clock_shift, .baud_tick, .tx_clock_pin_in(1'b0),
      .tx_clock_pin_out, .tx_clock_pin_oe, .power_active, .master_clock_enable,
      .port_coding_select, .protocol_select, .clock_mode_select, .continuous_transmit);
   scc_dma_host i_host (.core_clk, .rst_b, .dma_request, .slow, .transfer_acknowledge,
      .ack_count);

   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (strobe_exchange_active) seen_xchg <= 1'b1;
   end

   task automatic summarize;
      $display("checks=%0d bad=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
   endtask
   task automatic frame;
      @(negedge core_clk);
      transmit_frame_cmd = 1'b1;
      @(negedge core_clk);
      transmit_frame_cmd = 1'b0;
   endtask
   task automatic msg_end;
      @(negedge core_clk);
      message_end_cmd = 1'b1;
      @(negedge core_clk);
      message_end_cmd = 1'b0;
   endtask
   task automatic tick_byte;
      @(negedge core_clk);
      byte_tick = 1'b1;
      @(negedge core_clk);
      byte_tick = 1'b0;
   endtask
   task automatic qwr;
      @(negedge core_clk);
      transmit_queue_wr = 1'b1;
      @(negedge core_clk);
      transmit_queue_wr = 1'b0;
   endtask
   task automatic idle(input int c);
      repeat (c) @(negedge core_clk);
   endtask
   task automatic wait_drop;
      int w;
      w = 0;
      while (dma_request && w < 6000) begin
         @(negedge core_clk);
         w++;
      end
      if (w >= 6000) begin
         bad_count++;
         summarize();
      end
   endtask
   // sync on one tick first: the interval after a factor change may be partial
   task automatic baud_gap(output int c);
      c = 0;
      while (!baud_tick && c < 1100) begin
         @(negedge core_clk);
         c++;
      end
      c = 0;
      do begin
         @(negedge core_clk);
         c++;
      end while (!baud_tick && c < 1100);
   endtask

   initial begin
      #(60000 * 100);
      bad_count++;
      summarize();
   end

   initial begin
      idle(12);
      rst_b = 1'b1;
      chk(rts_b, 1'b1);
      chk(tx_source, scc_pkg::SRC_ONES);
      chk(dma_request, 1'b0);
      rd_chk(8'h2c, 8'h00);
      rd_chk(8'h2f, 8'h00);
      foreach (ROWS[r]) begin
         wr(ROWS[r][23:16], ROWS[r][15:8]);
         rd_chk(ROWS[r][23:16], ROWS[r][7:0]);
      end
      chk(continuous_transmit, 1'b1);
      for (int i = 0; i < 8; i++) begin
         wr(8'h2c, {2'b10, 1'b0, i[2:0], i[1:0]});
         chk(port_coding_select, i[2:0]);
         chk(protocol_select, i[1:0]);
         chk(power_active, 1'b1);
         wr(8'h2d, {5'h00, i[2:0]});
         chk(clock_mode_select, i[2:0]);
      end
      wr(8'h2c, 8'h40);
      chk(power_active, 1'b0);
      chk(master_clock_enable, 1'b1);
      wr(8'h2f, 8'h00);
      for (int k = 0; k < 2; k++) begin
         slow = k[0];
         wr(8'h2e, k ? 8'h04 : 8'h00);
         wr(8'h2a, k ? 8'h02 : 8'h01);
         wr(8'h2b, k ? 8'h81 : 8'h80);
         n0 = ack_count;
         seen_xchg = 1'b0;
         frame();
         idle(2);
         chk(dma_request, 1'b1);
         wait_drop();
         idle(20);
         chk(16'(ack_count - n0), k ? 16'h0102 : 16'h0001);
         chk(seen_xchg, k[0]);
      end
      wr(8'h2b, 8'h01);
      frame();
      idle(10);
      chk(dma_request, 1'b0);
      wr(8'h2a, 8'h01);
      wr(8'h2b, 8'h90);
      n0 = ack_count;
      frame();
      idle(60);
      chk(dma_request, 1'b1);
      chk(16'(ack_count - n0 > 2), 16'h0001);
      msg_end();
      wait_drop();
      tick_byte();
      chk(tx_source, scc_pkg::SRC_ONES);
      wr(8'h2b, 8'h00);
      for (int p = 0; p < 4; p++) begin
         wr(8'h2f, {p[1:0], 1'b1, 1'b1, p[0], 1'b1, 1'b1, 1'b0});
         wr(8'h2d, {4'h0, p[0], 3'h0});
         chk(tx_source, p[0] ? scc_pkg::SRC_SYNC : scc_pkg::SRC_ONES);
         frame();
         chk(crc_value, p[0] ? 16'h0000 : 16'hffff);
         n = 0;
         while (tx_source == scc_pkg::SRC_PRE && n < 20) begin
            tick_byte();
            n++;
         end
         chk(16'(n), 16'(1 << p));
         chk(tx_source, scc_pkg::SRC_DATA);
         tx_byte_valid = 1'b1;
         tx_byte = 8'h5a;
         tick_byte();
         msg_end();
         tx_byte_valid = 1'b0;
         tick_byte();
         chk(tx_source, scc_pkg::SRC_CRC);
         tick_byte();
         tick_byte();
         chk(tx_source, p[0] ? scc_pkg::SRC_SYNC : scc_pkg::SRC_ONES);
      end
      qwr();
      chk(transmit_queue_tag, 2'b11);
      wr(8'h2f, 8'h00);
      qwr();
      chk(transmit_queue_tag, 2'b00);
      wr(8'h2b, 8'h20);
      idle(6);
      chk(rx_enable, 1'b0);
      carrier_detect_in = 1'b1;
      idle(6);
      chk(rx_enable, 1'b1);
      wr(8'h2b, 8'h00);
      idle(6);
      chk(carrier_general, 1'b1);
      carrier_detect_in = 1'b0;
      idle(6);
      chk(carrier_general, 1'b0);
      wr(8'h2d, 8'h04);
      wr(8'h2c, 8'h80);
      wr(8'h2e, 8'h81);
      chk(swap_data_pins, 1'b1);
      chk(invert_data, 1'b1);
      chk(tx_clock_shift, 3'h0);
      wr(8'h2c, 8'h88);
      chk(invert_data, 1'b0);
      wr(8'h2c, 8'h84);
      transmitting = 1'b1;
      wr(8'h2e, 8'h80);
      idle(2);
      chk(rts_b, 1'b1);
      wr(8'h2e, 8'h00);
      idle(2);
      chk(rts_b, 1'b0);
      transmitting = 1'b0;
      frame_receiving = 1'b1;
      wr(8'h2e, 8'hc0);
      idle(2);
      chk(rts_b, 1'b0);
      frame_receiving = 1'b0;
      idle(2);
      chk(rts_b, 1'b1);
      wr(8'h2d, 8'h05);
      tx_shift_upper = 2'h3;
      rx_shift_upper = 2'h1;
      wr(8'h2e, 8'h28);
      chk(tx_clock_shift, 3'h7);
      chk(rx_clock_shift, 3'h2);
      wr(8'h2c, 8'h40);
      chk(master_clock_enable, 1'b0);
      wr(8'h2d, 8'h02);
      baud_value_low = 8'h03;
      wr(8'h2e, 8'h28);
      baud_gap(g);
      chk(16'(g), 16'h0008);
      chk(tx_clock_pin_oe, 1'b1);
      wr(8'h2e, 8'h00);
      baud_gap(g);
      chk(16'(g), 16'h0001);
      chk(tx_clock_pin_oe, 1'b0);
      wr(8'h2e, 8'h60);
      baud_gap(g);
      chk(16'(g), 16'h0208);
      summarize();
   end
endmodule // scc_chan_cfg_tb
